// file: src/spsc_defines.vh
// Constants of the system clock prescaler and sleep controller.
// Assumes a single 100 MHz master clock and an AXI4-Lite register bus.
`ifndef SPSC_DEFINES_VH
`define SPSC_DEFINES_VH

// Register byte offsets
`define SPSC_ADDR_PRESCALE     8'h00
`define SPSC_ADDR_SLEEP        8'h04
`define SPSC_ADDR_STATUS       8'h08

// Prescale register fields
`define SPSC_PS_UNLOCK_BIT     7
`define SPSC_PS_SEL_MSB        3
`define SPSC_PS_SEL_DIV1       4'h0
`define SPSC_PS_SEL_DIV8       4'h3
`define SPSC_PS_SEL_MAX        4'h8

// Sleep control register fields
`define SPSC_SL_ENABLE_BIT     5
`define SPSC_SL_MODE_MSB       4
`define SPSC_SL_MODE_LSB       3
`define SPSC_SL_RESET          8'h00

// Sleep mode encodings
`define SPSC_MODE_IDLE         2'h0
`define SPSC_MODE_NOISE        2'h1
`define SPSC_MODE_PDOWN        2'h2
`define SPSC_MODE_STANDBY      2'h3

// Timing counts
`define SPSC_UNLOCK_TICKS      3'h4
`define SPSC_WAKE_STALL_TICKS  3'h4
`define SPSC_STARTUP_CYCLES    4'h6

// Bus answers
`define SPSC_RESP_OKAY         2'h0
`define SPSC_RESP_SLVERR       2'h2

`endif

// file: src/spsc_divider.v
// Prescale counter producing one enable tick per divided clock period.
// Runs on the undivided master clock; the select comes from the top.
`timescale 1ns/100ps
`include "spsc_defines.vh"

module spsc_divider (
	input  wire       clk,
	input  wire       rst,
	input  wire [3:0] sel_reset,
	input  wire [3:0] sel_new,
	input  wire       sel_load,
	output reg        tick_q,
	output reg  [3:0] sel_act_q
);

	reg  [7:0] cnt_q;
	reg  [3:0] sel_pend_q;
	reg        pend_q;
	wire [3:0] sel_next;
	wire [3:0] sel_clamp;
	wire [7:0] reload;
	wire [8:0] reload_full;

	// A new select waits for the old period to end, so no short period
	assign sel_next  = pend_q ? sel_pend_q : sel_act_q; // see [RULE11]
	// Reserved codes behave as the largest factor
	assign sel_clamp = (sel_next > `SPSC_PS_SEL_MAX) ? `SPSC_PS_SEL_MAX : sel_next; // see [RULE9]
	// Factor 256 needs a ninth bit before the decrement
	assign reload_full = (9'h001 << sel_clamp) - 9'h001;
	assign reload      = reload_full[7:0];

	always @(posedge clk) begin
		if (rst) begin
			cnt_q      <= 8'h00;
			sel_act_q  <= sel_reset;
			sel_pend_q <= 4'h0;
			pend_q     <= 1'b0;
			tick_q     <= 1'b0;
		end else begin
			if (sel_load) begin
				sel_pend_q <= sel_new;
				pend_q     <= 1'b1;
			end
			if (cnt_q == 8'h00) begin
				// Old period ends here, new period counted from here
				tick_q    <= 1'b1; // see [RULE12]
				cnt_q     <= reload; // see [RULE13]
				sel_act_q <= sel_next;
				if (!sel_load) begin
					pend_q <= 1'b0;
				end
			end else begin
				tick_q <= 1'b0;
				cnt_q  <= cnt_q - 8'h01;
			end
		end
	end

endmodule // spsc_divider

// file: src/spsc_top.v
// Clock prescaler and sleep controller with AXI4-Lite registers.
// Assumes the core gives a one-cycle sleep pulse on CLOCK, and that
// clock domain enables are used as clock gates by the logic around it.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`include "spsc_defines.vh"

// Rules of the document
// [RULE1] Unlock bit sets only when written one with all other bits zero.
// [RULE2] Unlock bit clears after four ticks or when a select is written.
// [RULE3] Rewriting the unlock bit while open neither restarts nor clears it.
// [RULE4] Prescale bits 6 to 4 read zero and ignore writes.
// [RULE5] Software unlocks, then writes the select within four ticks.
// [RULE6] Software keeps interrupts off during the two-write change.
// [RULE7] Select resets to 0000, or 0011 with the divide-by-eight fuse.
// [RULE8] Any select value is accepted via unlock, whatever the fuse.
// [RULE9] Select n divides by two to the n; codes 9 to 15 reserved.
// [RULE10] Divided clock feeds processor, flash, I/O and converter domains.
// [RULE11] Division changes are glitch free; no period shorter than both.
// [RULE12] New rate is active after one old plus one to two new periods.
// [RULE13] Prescaler counts on the master clock; its state is unreadable.
// [RULE14] Sleep starts only on a sleep instruction with sleep enable set.
// [RULE15] Mode field: 00 idle, 01 noise reduction, 10 power-down, 11 standby.
// [RULE16] Enabled interrupt wakes; stall four ticks after start-up, then resume.
// [RULE17] Register file and static memory keep contents across sleep.
// [RULE18] Reset during sleep wakes and restarts from the reset vector.
// [RULE19] Idle stops only processor and flash clocks.
// [RULE20] Idle wakes on external and internal interrupts.
// [RULE21] Converter enabled on idle entry starts a conversion.
// [RULE22] Software sets sleep enable just before sleep, clears after waking.
// [RULE23] Noise reduction halts I/O, processor and flash; converter runs.
// [RULE24] Power-down stops the oscillator and every generated clock.
// [RULE25] Unlock window counts divided ticks and closes on reset.
module spsc_top (
	input  wire        CLOCK,
	input  wire        SYS_RST,
	input  wire        DIV8_FUSE,
	input  wire        SLEEP_INSTR,
	input  wire        ADC_ENABLED,
	input  wire        WAKE_PIN_IRQ,
	input  wire        WAKE_IO_IRQ,
	input  wire        WAKE_ADC_IRQ,
	input  wire        WAKE_NVM_IRQ,
	input  wire        WAKE_WDT_IRQ,
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output reg         S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output reg         S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output reg         S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	output reg         CPU_CLK_EN,
	output reg         FLASH_CLK_EN,
	output reg         IO_CLK_EN,
	output reg         ADC_CLK_EN,
	output reg         OSC_ENABLE,
	output reg         ADC_START,
	output reg         CORE_STALL,
	output reg         SLEEPING
);

	localparam [1:0] ST_ACTIVE  = 2'h0;
	localparam [1:0] ST_ASLEEP  = 2'h1;
	localparam [1:0] ST_STARTUP = 2'h2;
	localparam [1:0] ST_STALL   = 2'h3;

	// Pin synchronisers; fuse flops carry no reset so reset can sample them
	reg        fuse_s1_q;
	reg        fuse_s2_q;
	reg        pin_s1_q;
	reg        pin_s2_q;

	// Bus state
	reg        aw_have_q;
	reg        w_have_q;
	reg  [7:0] awaddr_q;
	reg  [7:0] wdata_q;
	reg        wstrb0_q;
	wire       do_write;
	wire       wr_ps;
	wire       wr_sl;
	reg  [31:0] rdata_d;
	reg  [1:0]  rresp_d;

	// Control registers
	reg        unlock_q;
	reg  [2:0] unlock_cnt_q;
	reg  [3:0] sel_q;
	reg        sel_load_d;
	reg        sleep_en_q;
	reg  [1:0] sleep_mode_q;
	wire [3:0] sel_reset;
	wire       tick;
	wire [3:0] sel_act;

	// Sleep sequencer
	reg  [1:0] state_q;
	reg  [1:0] state_d;
	reg  [1:0] mode_q;
	reg  [3:0] wait_cnt_q;
	reg        wake_d;
	reg        cpu_run;
	reg        io_run;
	reg        adc_run;

	always @(posedge CLOCK) begin
		fuse_s1_q <= DIV8_FUSE;
		fuse_s2_q <= fuse_s1_q;
		pin_s1_q  <= WAKE_PIN_IRQ;
		pin_s2_q  <= pin_s1_q;
	end

	assign sel_reset = fuse_s2_q ? `SPSC_PS_SEL_DIV8 : `SPSC_PS_SEL_DIV1; // see [RULE7]

	spsc_divider u_div (
		.clk       (CLOCK),
		.rst       (SYS_RST),
		.sel_reset (sel_reset),
		.sel_new   (wdata_q[`SPSC_PS_SEL_MSB:0]),
		.sel_load  (sel_load_d),
		.tick_q    (tick),
		.sel_act_q (sel_act)
	);

	// Write channel: address and data taken in either order
	assign do_write = aw_have_q && w_have_q && !S_AXI_BVALID;
	assign wr_ps    = do_write && wstrb0_q && (awaddr_q[7:2] == `SPSC_ADDR_PRESCALE >> 2);
	assign wr_sl    = do_write && wstrb0_q && (awaddr_q[7:2] == `SPSC_ADDR_SLEEP >> 2);

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `SPSC_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 8'h00;
			wstrb0_q      <= 1'b0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_q     <= 1'b1;
				awaddr_q      <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_q     <= 1'b1;
				wdata_q      <= S_AXI_WDATA[7:0];
				wstrb0_q     <= S_AXI_WSTRB[0];
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if (awaddr_q[7:2] <= `SPSC_ADDR_STATUS >> 2) begin
					S_AXI_BRESP <= `SPSC_RESP_OKAY;
				end else begin
					S_AXI_BRESP <= `SPSC_RESP_SLVERR;
				end
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// Read mux; counter state is deliberately not visible
	always @* begin
		rdata_d = 32'h0000_0000;
		rresp_d = `SPSC_RESP_OKAY;
		case (S_AXI_ARADDR[7:2])
			`SPSC_ADDR_PRESCALE >> 2: begin
				rdata_d[`SPSC_PS_UNLOCK_BIT]  = unlock_q;
				rdata_d[`SPSC_PS_SEL_MSB:0]   = sel_q; // see [RULE4] [RULE13]
			end
			`SPSC_ADDR_SLEEP >> 2: begin
				rdata_d[`SPSC_SL_ENABLE_BIT]  = sleep_en_q;
				rdata_d[`SPSC_SL_MODE_MSB:`SPSC_SL_MODE_LSB] = sleep_mode_q;
			end
			`SPSC_ADDR_STATUS >> 2: begin
				rdata_d[7:4] = sel_act;
				rdata_d[3:2] = state_q;
				rdata_d[1:0] = mode_q;
			end
			default: begin
				rresp_d = `SPSC_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= `SPSC_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= rdata_d;
				S_AXI_RRESP   <= rresp_d;
			end
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// Select write is honoured only while the window is open
	always @* begin
		sel_load_d = wr_ps && unlock_q && !wdata_q[`SPSC_PS_UNLOCK_BIT]; // see [RULE8]
	end

	// Prescale register and unlock window
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			unlock_q     <= 1'b0; // see [RULE25]
			unlock_cnt_q <= 3'h0;
			sel_q        <= sel_reset; // see [RULE7]
		end else begin
			if (sel_load_d) begin
				sel_q    <= wdata_q[`SPSC_PS_SEL_MSB:0];
				unlock_q <= 1'b0; // see [RULE2]
			end else if (wr_ps && !unlock_q && (wdata_q == 8'h80)) begin
				// Bits 6 to 4 must be zero too, so they can never be stored
				unlock_q     <= 1'b1; // see [RULE1] [RULE4]
				unlock_cnt_q <= `SPSC_UNLOCK_TICKS;
			end else if (unlock_q && tick) begin
				// A repeated unlock write falls through to here untouched
				if (unlock_cnt_q == 3'h1) begin
					unlock_q <= 1'b0; // see [RULE2] [RULE3] [RULE25]
				end
				unlock_cnt_q <= unlock_cnt_q - 3'h1;
			end
		end
	end

	// Sleep control register
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			sleep_en_q   <= |(`SPSC_SL_RESET & (8'h01 << `SPSC_SL_ENABLE_BIT));
			sleep_mode_q <= 2'h0;
		end else if (wr_sl) begin
			sleep_en_q   <= wdata_q[`SPSC_SL_ENABLE_BIT];
			sleep_mode_q <= wdata_q[`SPSC_SL_MODE_MSB:`SPSC_SL_MODE_LSB];
		end
	end

	// Wake sources per mode; idle takes everything
	always @* begin
		case (mode_q)
			`SPSC_MODE_IDLE: begin
				wake_d = pin_s2_q | WAKE_IO_IRQ | WAKE_ADC_IRQ | WAKE_NVM_IRQ
					| WAKE_WDT_IRQ; // see [RULE20]
			end
			`SPSC_MODE_NOISE: begin
				wake_d = pin_s2_q | WAKE_ADC_IRQ | WAKE_NVM_IRQ | WAKE_WDT_IRQ;
			end
			default: begin
				wake_d = pin_s2_q | WAKE_WDT_IRQ;
			end
		endcase
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_ACTIVE: begin
				if (SLEEP_INSTR && sleep_en_q) begin
					state_d = ST_ASLEEP; // see [RULE14]
				end
			end
			ST_ASLEEP: begin
				if (wake_d) begin
					// Only power-down has an oscillator to restart
					if (mode_q == `SPSC_MODE_PDOWN) begin
						state_d = ST_STARTUP;
					end else begin
						state_d = ST_STALL;
					end
				end
			end
			ST_STARTUP: begin
				if (wait_cnt_q == 4'h1) begin
					state_d = ST_STALL;
				end
			end
			ST_STALL: begin
				if (tick && wait_cnt_q == 4'h1) begin
					state_d = ST_ACTIVE; // see [RULE16]
				end
			end
			default: begin
				state_d = ST_ACTIVE;
			end
		endcase
	end

	// Reset returns straight to active, so execution restarts at the vector
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			state_q    <= ST_ACTIVE; // see [RULE18]
			mode_q     <= `SPSC_MODE_IDLE;
			wait_cnt_q <= 4'h0;
			ADC_START  <= 1'b0;
		end else begin
			state_q   <= state_d;
			ADC_START <= 1'b0;
			if (state_q == ST_ACTIVE && state_d == ST_ASLEEP) begin
				mode_q <= sleep_mode_q; // see [RULE15]
				if (ADC_ENABLED && sleep_mode_q <= `SPSC_MODE_NOISE) begin
					ADC_START <= 1'b1; // see [RULE21]
				end
			end
			if (state_d == ST_STARTUP && state_q == ST_ASLEEP) begin
				wait_cnt_q <= `SPSC_STARTUP_CYCLES;
			end else if (state_d == ST_STALL && state_q != ST_STALL) begin
				wait_cnt_q <= {1'b0, `SPSC_WAKE_STALL_TICKS}; // see [RULE16]
			end else if (state_q == ST_STARTUP) begin
				wait_cnt_q <= wait_cnt_q - 4'h1;
			end else if (state_q == ST_STALL && tick) begin
				wait_cnt_q <= wait_cnt_q - 4'h1;
			end
		end
	end

	// Domain gating; only clocks stop, storage is never cleared by sleep
	always @* begin
		cpu_run = (state_q == ST_ACTIVE); // see [RULE17] [RULE19]
		io_run  = (state_q != ST_ASLEEP) || (mode_q == `SPSC_MODE_IDLE); // see [RULE23]
		adc_run = io_run || (mode_q == `SPSC_MODE_NOISE); // see [RULE23]
	end

	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			CPU_CLK_EN   <= 1'b0;
			FLASH_CLK_EN <= 1'b0;
			IO_CLK_EN    <= 1'b0;
			ADC_CLK_EN   <= 1'b0;
			OSC_ENABLE   <= 1'b1;
			CORE_STALL   <= 1'b0;
			SLEEPING     <= 1'b0;
		end else begin
			CPU_CLK_EN   <= tick && cpu_run; // see [RULE10]
			FLASH_CLK_EN <= tick && cpu_run; // see [RULE10]
			IO_CLK_EN    <= tick && io_run; // see [RULE10]
			ADC_CLK_EN   <= tick && adc_run; // see [RULE10]
			// Standby keeps the oscillator for a fast wake
			OSC_ENABLE   <= !(state_q == ST_ASLEEP && mode_q == `SPSC_MODE_PDOWN); // see [RULE24]
			CORE_STALL   <= (state_q == ST_STARTUP) || (state_q == ST_STALL);
			SLEEPING     <= (state_q == ST_ASLEEP);
		end
	end

endmodule // spsc_top

// file: verif/spsc_core_model.sv
// Core model: register master and sleep instruction.
// Assumes it shares the bench clock; the bench calls its tasks.
`timescale 1ns/100ps
`include "spsc_defines.vh"
module spsc_core_model (
	input  logic        clock,
	output logic [7:0]  awaddr,
	output logic        awvalid,
	input  logic        awready,
	output logic [31:0] wdata,
	output logic [3:0]  wstrb,
	output logic        wvalid,
	input  logic        wready,
	input  logic [1:0]  bresp,
	input  logic        bvalid,
	output logic        bready,
	output logic [7:0]  araddr,
	output logic        arvalid,
	input  logic        arready,
	input  logic [31:0] rdata,
	input  logic [1:0]  rresp,
	input  logic        rvalid,
	output logic        rready,
	output logic        sleep_instr
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, sleep_instr} = '0;
	end
	task automatic wr(input logic [7:0] a, d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		r = bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	// Two writes back to back, nothing may slip between them
	task automatic set_div(input logic [3:0] sel);
		logic [1:0] r;
		wr(`SPSC_ADDR_PRESCALE, 8'h80, 4'hF, r);
		wr(`SPSC_ADDR_PRESCALE, {4'h0, sel}, 4'hF, r);
	endtask
	task automatic go_sleep(input logic en, input logic [1:0] m);
		logic [1:0] r;
		wr(`SPSC_ADDR_SLEEP, {2'h0, en, m, 3'h0}, 4'hF, r);
		@(posedge clock);
		sleep_instr <= 1'b1;
		@(posedge clock);
		sleep_instr <= 1'b0;
	endtask
endmodule // spsc_core_model

// file: verif/spsc_props.sv
// Checker for spsc_top: bus answers, sleep entry and clock gating.
// Assumes one clock domain; bound to spsc_top below.
`timescale 1ns/100ps
`include "spsc_defines.vh"
module spsc_props (
	input logic        CLOCK,
	input logic        SYS_RST,
	input logic        SLEEP_INSTR,
	input logic        S_AXI_AWVALID,
	input logic        S_AXI_AWREADY,
	input logic        S_AXI_WVALID,
	input logic        S_AXI_WREADY,
	input logic        S_AXI_BVALID,
	input logic [7:0]  S_AXI_ARADDR,
	input logic        S_AXI_ARVALID,
	input logic        S_AXI_ARREADY,
	input logic [31:0] S_AXI_RDATA,
	input logic        S_AXI_RVALID,
	input logic        CPU_CLK_EN,
	input logic        FLASH_CLK_EN,
	input logic        IO_CLK_EN,
	input logic        ADC_CLK_EN,
	input logic        OSC_ENABLE,
	input logic        ADC_START,
	input logic        SLEEPING
);
	logic rd_ps_q;
	// Which register the pending read addressed
	always @(posedge CLOCK) begin
		if (SYS_RST)
			rd_ps_q <= 1'b0;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			rd_ps_q <= (S_AXI_ARADDR == `SPSC_ADDR_PRESCALE);
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	a_write_answer:
		assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##2 S_AXI_BVALID) else $error("write not answered");
	a_read_answer:
		assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	a_resv_bits_zero:
		assert property (S_AXI_RVALID && rd_ps_q |-> S_AXI_RDATA[6:4] == 3'h0)
		else $error("reserved prescale bits set");
	a_sleep_cause:
		assert property ($rose(SLEEPING) |-> $past(SLEEP_INSTR) || $past(SLEEP_INSTR, 2)
		|| $past(SLEEP_INSTR, 3)) else $error("sleep without instruction");
	a_cpu_halted:
		assert property (SLEEPING && $past(SLEEPING) |-> !CPU_CLK_EN && !FLASH_CLK_EN)
		else $error("cpu clock runs asleep");
	a_pdown_quiet:
		assert property (SLEEPING && $past(SLEEPING) && !OSC_ENABLE |-> !IO_CLK_EN && !ADC_CLK_EN)
		else $error("clock runs in power-down");
	a_domains_tied:
		assert property (CPU_CLK_EN |-> FLASH_CLK_EN && IO_CLK_EN && ADC_CLK_EN)
		else $error("domain enables differ");
	a_start_pulse:
		assert property (ADC_START |=> !ADC_START)
		else $error("conversion start too long");
	c_sleep: cover property ($rose(SLEEPING));
	c_start: cover property (ADC_START);
	c_osc_off: cover property (!OSC_ENABLE);
endmodule // spsc_props

bind spsc_top spsc_props u_props (.*);

// file: verif/test_sysclk_prescaler_sleep_ctrl.sv
// Bench for spsc_top: prescale unlock, divider rates, sleep modes.
// Assumes spsc_core_model as register master and the bound checker.
`timescale 1ns/100ps
`include "spsc_defines.vh"
module test_sysclk_prescaler_sleep_ctrl;
	logic        clock, sys_rst, fuse, adc_on, sleep_instr;
	logic [4:0]  irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        cpu_en, fl_en, io_en, adc_en, osc_en, adc_start, stall, sleeping;
	int          fails, n_checks, n_cpu, n_io, n_adc, n_start, s0, n;
	logic [3:0]  codes[4] = '{4'h8, 4'h1, 4'h9, 4'h0};
	int          src[5] = '{1, 2, 0, 4, 3};
	spsc_core_model core (.*);
	spsc_top dut (
		.CLOCK(clock), .SYS_RST(sys_rst), .DIV8_FUSE(fuse), .SLEEP_INSTR(sleep_instr),
		.ADC_ENABLED(adc_on), .WAKE_PIN_IRQ(irq[0]), .WAKE_IO_IRQ(irq[1]),
		.WAKE_ADC_IRQ(irq[2]), .WAKE_NVM_IRQ(irq[3]), .WAKE_WDT_IRQ(irq[4]),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CPU_CLK_EN(cpu_en), .FLASH_CLK_EN(fl_en), .IO_CLK_EN(io_en), .ADC_CLK_EN(adc_en),
		.OSC_ENABLE(osc_en), .ADC_START(adc_start), .CORE_STALL(stall), .SLEEPING(sleeping));
	initial clock = 1'b0;
	always #5 clock = ~clock;
	// Outputs are unknown before the first reset edge
	always @(posedge clock) if (!sys_rst) n_start <= n_start + adc_start;
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input logic [7:0] a, e);
		core.rd(a, d, r);
		chk("rdata", d, {24'h0, e});
	endtask
	// Samples before the edge updates land, so counts are race free
	task automatic watch(input int k);
		{n_cpu, n_io, n_adc} = '0;
		repeat (k) begin
			@(posedge clock);
			n_cpu += cpu_en;
			n_io += io_en;
			n_adc += adc_en;
		end
	endtask
	// Three ticks first, so the switch-over interval is passed
	task automatic period(input logic [31:0] p);
		repeat (3) begin
			do @(posedge clock); while (!cpu_en);
		end
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!cpu_en);
		chk("period", n, p);
	endtask
	task automatic give_verdict;
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{fails, n_checks, n_start} = '0;
		{sys_rst, fuse, adc_on, irq} = 8'hE0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		rdc(`SPSC_ADDR_PRESCALE, 8'h03);
		rdc(`SPSC_ADDR_SLEEP, 8'h00);
		core.rd(8'h0C, d, r);
		chk("rresp", r, `SPSC_RESP_SLVERR);
		core.wr(8'h0C, 8'h00, 4'hF, r);
		chk("bresp", r, `SPSC_RESP_SLVERR);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h05, 4'hF, r);
		chk("bresp", r, `SPSC_RESP_OKAY);
		rdc(`SPSC_ADDR_PRESCALE, 8'h03);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h81, 4'hF, r);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h05, 4'hF, r);
		rdc(`SPSC_ADDR_PRESCALE, 8'h03);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h80, 4'hF, r);
		rdc(`SPSC_ADDR_PRESCALE, 8'h83);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h80, 4'hF, r);
		rdc(`SPSC_ADDR_PRESCALE, 8'h83);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h72, 4'hF, r);
		rdc(`SPSC_ADDR_PRESCALE, 8'h02);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h80, 4'h0, r);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h05, 4'hF, r);
		rdc(`SPSC_ADDR_PRESCALE, 8'h02);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h80, 4'hF, r);
		repeat (80) @(posedge clock);
		rdc(`SPSC_ADDR_PRESCALE, 8'h02);
		core.wr(`SPSC_ADDR_PRESCALE, 8'h05, 4'hF, r);
		rdc(`SPSC_ADDR_PRESCALE, 8'h02);
		for (int i = 0; i < 4; i++) begin
			core.set_div(codes[i]);
			rdc(`SPSC_ADDR_PRESCALE, {4'h0, codes[i]});
			period(codes[i] > 4'h8 ? 32'h100 : 32'h1 << codes[i]);
		end
		core.wr(`SPSC_ADDR_SLEEP, 8'hFF, 4'hF, r);
		rdc(`SPSC_ADDR_SLEEP, 8'h38);
		core.go_sleep(1'b0, 2'h0);
		repeat (8) @(posedge clock);
		chk("sleeping", sleeping, 1'h0);
		for (int m = 0; m < 5; m++) begin
			s0 = n_start;
			// Last pass is idle again with the converter off
			adc_on <= (m < 4);
			core.go_sleep(1'b1, m[1:0]);
			repeat (4) @(posedge clock);
			watch(16);
			chk("sleeping", sleeping, 1'h1);
			chk("cpu", n_cpu, 32'h0);
			chk("io", n_io != 0, m[1:0] == 2'h0);
			chk("adc", n_adc != 0, m[1:0] < 2'h2);
			chk("osc", osc_en, m != 2);
			chk("start", n_start - s0, m < 2);
			rdc(`SPSC_ADDR_STATUS, {4'h0, 2'h1, m[1:0]});
			irq[src[m]] <= 1'b1;
			do @(posedge clock); while (!stall);
			n = 0;
			while (stall) begin
				n++;
				@(posedge clock);
			end
			chk("stall", n, m == 2 ? 32'hA : 32'h4);
			irq <= 5'h0;
			watch(8);
			chk("cpu", n_cpu != 0, 1'h1);
			core.wr(`SPSC_ADDR_SLEEP, 8'h00, 4'hF, r);
		end
		core.go_sleep(1'b1, `SPSC_MODE_PDOWN);
		repeat (4) @(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		chk("sleeping", sleeping, 1'h0);
		chk("osc", osc_en, 1'h1);
		sys_rst <= 1'b0;
		rdc(`SPSC_ADDR_SLEEP, 8'h00);
		rdc(`SPSC_ADDR_PRESCALE, 8'h03);
		give_verdict;
	end
	// Whole run is a few thousand cycles; this leaves ample margin
	initial begin
		#200000;
		fails++;
		give_verdict;
	end
endmodule // test_sysclk_prescaler_sleep_ctrl
